// file: cei_dev.sv
// corrected-error interrupt device: bank threshold logic, capability and vector entry
//
// Design decision made here: the link register port.
`timescale 1ns/100ps
module cei_dev (
    input wire logic clk_i,
    input wire logic rst_i,
    cei_if.dev link,
    input wire logic err_valid_i,
    input wire logic [cei_pkg::BANK_W-1:0] err_bank_i,
    input wire cei_pkg::cei_kind_e err_kind_i,
    input wire cei_pkg::cei_scope_e err_scope_i,
    output logic mce_o
);

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // true when addr falls in the four-entry bank window at base
    function automatic logic in_bank_win(input logic [11:0] a, input logic [11:0] base);
        in_bank_win = (a[11:cei_pkg::BANK_W] == base[11:cei_pkg::BANK_W]);
    endfunction

    // threads that share the failing structure
    function automatic logic [cei_pkg::NTHR-1:0] scope_mask(input cei_pkg::cei_scope_e s);
        case (s)
            cei_pkg::SCOPE_T0: scope_mask = 2'h1;
            cei_pkg::SCOPE_T1: scope_mask = 2'h2;
            default: scope_mask = 2'h3; // shared cache or whole package
        endcase
    endfunction

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic ctl_en [cei_pkg::NBANK];                       // bank signalling enable
    logic [cei_pkg::THR_W-1:0] ctl_thr [cei_pkg::NBANK]; // bank threshold
    logic [cei_pkg::DATA_W-1:0] stat [cei_pkg::NBANK];   // bank status word
    logic fired [cei_pkg::NBANK];                        // request already given
    logic [31:0] vec_entry;                              // vector entry
    logic ack;
    logic [cei_pkg::DATA_W-1:0] rdata;
    logic [cei_pkg::NTHR-1:0] irq;
    logic [cei_pkg::VEC_W-1:0] vector;

    // -------------------------------------------------------------
    // decode
    // -------------------------------------------------------------
    wire wr = link.req & link.we;
    wire hit_ctl = in_bank_win(link.addr, cei_pkg::ADDR_CTL_BASE);
    wire hit_stat = in_bank_win(link.addr, cei_pkg::ADDR_STAT_BASE);
    wire hit_gcap = (link.addr == cei_pkg::ADDR_GCAP);
    wire hit_vec = (link.addr == cei_pkg::ADDR_VEC);
    // bank index of the addressed register inside its four-entry window
    wire [cei_pkg::BANK_W-1:0] rsel = link.addr[cei_pkg::BANK_W-1:0];
    // only the corrected-class kinds use this path; system-level and exception-path kinds do not
    wire cmc_kind = err_valid_i & ((err_kind_i == cei_pkg::KIND_CORR) | (err_kind_i == cei_pkg::KIND_UNCORRECTED_NO_ACTION)
                    | (err_kind_i == cei_pkg::KIND_SRAO_CMC));
    // threshold part of the write data: the compared bits and the stored top bit
    wire [cei_pkg::THR_CMP_W-1:0] thr_in = link.wdata[cei_pkg::THR_CMP_W-1:0];
    wire thr_top = link.wdata[cei_pkg::THR_W-1];
    // saturating write of the compared bits; a probe with all ones reads back the maximum
    wire [14:0] thr_wr = (thr_in > cei_pkg::THR_MAX) ? cei_pkg::THR_MAX : thr_in;

    // capability word is constant
    wire [cei_pkg::DATA_W-1:0] gcap_word = (64'(cei_pkg::NBANK) << cei_pkg::GCAP_CNT_LSB)
                                         | (64'h1 << cei_pkg::GCAP_CEI_BIT)
                                         | (64'(cei_pkg::SER_SUPPORT) << cei_pkg::GCAP_SER_BIT);

    // control word as seen on a read: enable at 30, threshold at 15:0, rest zero
    wire [cei_pkg::DATA_W-1:0] ctl_word = (64'(ctl_en[rsel]) << cei_pkg::CTL_EN_BIT)
                                        | 64'(ctl_thr[rsel]);

    wire [cei_pkg::DATA_W-1:0] rd_word = hit_gcap ? gcap_word
                                       : hit_ctl ? ctl_word
                                       : hit_stat ? stat[rsel]
                                       : hit_vec ? 64'(vec_entry)
                                       : 64'h0; // unmapped reads zero

    wire [cei_pkg::NBANK-1:0] bank_fire;

    // -------------------------------------------------------------
    // per-bank logic
    // -------------------------------------------------------------
    // no input exists for the global or per-bank error enables: this path never looks at them
    genvar gi;
    generate
        for (gi = 0; gi < cei_pkg::NBANK; gi++)
        begin : g_bank
            wire wr_ctl = wr & hit_ctl & (rsel == cei_pkg::BANK_W'(gi));
            wire wr_stat = wr & hit_stat & (rsel == cei_pkg::BANK_W'(gi));
            // a bank that cannot signal records no corrected-class errors at all
            wire ev = cmc_kind & (err_bank_i == cei_pkg::BANK_W'(gi)) & cei_pkg::BANK_HAS_CEI[gi];
            // a status write lands first; an error in the same cycle still counts on top
            wire [cei_pkg::DATA_W-1:0] stat_base = wr_stat ? link.wdata : stat[gi];
            wire [14:0] cnt_base = stat_base[cei_pkg::CNT_MSB:cei_pkg::CNT_LSB];
            wire [14:0] next_cnt = (ev & (cnt_base != cei_pkg::CNT_MAX)) ? cnt_base + 15'h1 : cnt_base;
            wire fired_base = wr_stat ? 1'b0 : fired[gi];
            wire [14:0] thr = ctl_thr[gi][14:0];
            // compare the count after this error with the threshold; zero threshold never fires
            assign bank_fire[gi] = ev & ctl_en[gi] & ~fired_base & (thr != 15'h0)
                                 & (next_cnt >= thr);

            // control register: enable sticks only in signalling banks, threshold only where kept
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    ctl_en[gi] <= 1'b0;
                    ctl_thr[gi] <= 16'h0;
                end
                else if (wr_ctl)
                begin
                    ctl_en[gi] <= link.wdata[cei_pkg::CTL_EN_BIT] & cei_pkg::BANK_HAS_CEI[gi];
                    ctl_thr[gi] <= cei_pkg::BANK_HAS_THR[gi] ? {thr_top, thr_wr} : 16'h0;
                end
            end

            // status register: software write, then hardware count and valid
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    stat[gi] <= 64'h0;
                    fired[gi] <= 1'b0;
                end
                else
                begin
                    stat[gi][cei_pkg::CNT_MSB:cei_pkg::CNT_LSB] <= next_cnt;
                    stat[gi][cei_pkg::STAT_VAL_BIT] <= stat_base[cei_pkg::STAT_VAL_BIT] | ev;
                    stat[gi][cei_pkg::CNT_LSB-1:0] <= stat_base[cei_pkg::CNT_LSB-1:0];
                    stat[gi][cei_pkg::STAT_VAL_BIT-1:cei_pkg::CNT_MSB+1] <=
                        stat_base[cei_pkg::STAT_VAL_BIT-1:cei_pkg::CNT_MSB+1];
                    // set wins over the clear carried by a status write
                    fired[gi] <= fired_base | bank_fire[gi];
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------
    // vector entry and register answers
    // -------------------------------------------------------------
    // the answer comes one cycle after every request, mapped or not
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            vec_entry <= cei_pkg::VEC_RESET;
            ack <= 1'b0;
            rdata <= 64'h0;
        end
        else
        begin
            if (wr & hit_vec)
                vec_entry <= link.wdata[31:0];
            ack <= link.req;
            if (link.req & ~link.we)
                rdata <= rd_word;
        end
    end

    // -------------------------------------------------------------
    // interrupt delivery
    // -------------------------------------------------------------
    // a masked entry still latches fired: software sees the count and rearms by clearing status
    // the scope of the same event picks which threads hear it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq <= 2'h0;
            vector <= 8'h0;
            mce_o <= 1'b0;
        end
        else
        begin
            irq <= ((|bank_fire) & ~vec_entry[cei_pkg::VEC_MASK_BIT]) ? scope_mask(err_scope_i) : 2'h0;
            vector <= vec_entry[cei_pkg::VEC_W-1:0];
            mce_o <= err_valid_i & (err_kind_i == cei_pkg::KIND_UCR_MCE);
        end
    end

    assign link.ack = ack;
    assign link.rdata = rdata;
    assign link.irq = irq;
    assign link.vector = vector;

endmodule

// file: cei_pkg.sv
// shared constants and types for the corrected-error interrupt device and its host controller
package cei_pkg;

    // -------------------------------------------------------------
    // sizes
    // -------------------------------------------------------------
    localparam int NBANK = 4;          // implemented error banks
    localparam int BANK_W = 2;         // bank index width
    localparam int NTHR = 2;           // logical processors served
    localparam int ADDR_W = 12;        // register index width on the link
    localparam int DATA_W = 64;        // register data width on the link

    // -------------------------------------------------------------
    // device register map (link addresses)
    // -------------------------------------------------------------
    localparam logic [11:0] ADDR_GCAP = 12'h000;      // global_capability, read only
    localparam logic [11:0] ADDR_CTL_BASE = 12'h100;  // bank_interrupt_control, one per bank
    localparam logic [11:0] ADDR_STAT_BASE = 12'h200; // bank_error_status, one per bank
    localparam logic [11:0] ADDR_VEC = 12'h2f0;       // corrected_interrupt_vector_entry

    // -------------------------------------------------------------
    // field layouts
    // -------------------------------------------------------------
    localparam int GCAP_CNT_LSB = 0;   // bank count 7:0
    localparam int GCAP_CNT_W = 8;
    localparam int GCAP_CEI_BIT = 10;  // corrected-error interrupt supported
    localparam int GCAP_SER_BIT = 24;  // recovery_support_flag
    localparam int CTL_EN_BIT = 30;    // per-bank signalling enable
    localparam int THR_W = 16;         // threshold field 15:0
    localparam int THR_CMP_W = 15;     // compared part 14:0
    localparam int CNT_LSB = 38;       // corrected count 52:38
    localparam int CNT_MSB = 52;
    localparam int STAT_VAL_BIT = 63;  // status valid
    localparam int VEC_W = 8;          // vector number 7:0
    localparam int VEC_MASK_BIT = 16;  // entry mask

    // -------------------------------------------------------------
    // implementation choices and reset values
    // -------------------------------------------------------------
    localparam logic [NBANK-1:0] BANK_HAS_THR = 4'h7;   // banks 0..2 threshold, bank 3 not
    localparam logic [NBANK-1:0] BANK_HAS_CEI = 4'h7;   // same banks signal
    localparam logic [14:0] THR_MAX = 15'h0fff;          // largest supported threshold
    localparam logic [14:0] CNT_MAX = 15'h7fff;          // count saturates here
    localparam logic SER_SUPPORT = 1'b1;
    localparam logic [31:0] VEC_RESET = 32'h0001_0000;   // masked, vector 0

    // -------------------------------------------------------------
    // error event kinds and scopes
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        KIND_CORR = 3'b000,     // corrected error
        KIND_UNCORRECTED_NO_ACTION = 3'b001,     // uncorrected_no_action
        KIND_SRAO_CMC = 3'b010, // recoverable_uncorrected_error reported as corrected
        KIND_UCR_MCE = 3'b011,  // recoverable_uncorrected_error via exception path
        KIND_SYSTEM = 3'b100    // outside the package
    } cei_kind_e;

    typedef enum logic [1:0] {
        SCOPE_T0 = 2'b00,
        SCOPE_T1 = 2'b01,
        SCOPE_SHARED = 2'b10,
        SCOPE_PACKAGE = 2'b11
    } cei_scope_e;

    // -------------------------------------------------------------
    // host wishbone map and command bits
    // -------------------------------------------------------------
    localparam logic [7:0] WB_ADDR = 8'h00;
    localparam logic [7:0] WB_WLO = 8'h04;
    localparam logic [7:0] WB_WHI = 8'h08;
    localparam logic [7:0] WB_CMD = 8'h0c;
    localparam logic [7:0] WB_RLO = 8'h10;
    localparam logic [7:0] WB_RHI = 8'h14;
    localparam logic [7:0] WB_PEND = 8'h18;
    localparam int CMD_RD_BIT = 0;     // write 1: start a read / read: busy
    localparam int CMD_WR_BIT = 1;     // write 1: start a write / read: done

    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_WAIT = 2'b01
    } cei_hst_e;

endpackage

// file: cei_if.sv
// link between the device's register port and interrupt lines and the host controller
`timescale 1ns/100ps
interface cei_if;
    logic req;                               // one-cycle request
    logic we;                                // write when high
    logic [cei_pkg::ADDR_W-1:0] addr;
    logic [cei_pkg::DATA_W-1:0] wdata;
    logic ack;                               // one-cycle answer
    logic [cei_pkg::DATA_W-1:0] rdata;
    logic [cei_pkg::NTHR-1:0] irq;           // one-cycle interrupt per thread
    logic [cei_pkg::VEC_W-1:0] vector;       // vector delivered with irq

    modport dev (input req, we, addr, wdata, output ack, rdata, irq, vector);
    modport host (output req, we, addr, wdata, input ack, rdata, irq, vector);
endinterface

// file: cei_host.sv
// host controller: wishbone registers that issue link reads and writes and collect interrupts
`timescale 1ns/100ps
module cei_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    cei_if.host link
);

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        for (int b = 0; b < 4; b++)
            merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    endfunction

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    cei_pkg::cei_hst_e state;
    logic [31:0] tgt_addr;          // link address, low 12 bits used
    logic [63:0] wdata;             // link write data
    logic [63:0] rdata;             // last link read data
    logic busy;
    logic done;                     // sticky, cleared by starting a command
    logic [cei_pkg::NTHR-1:0] pend; // sticky interrupts per thread, write one to clear
    logic [cei_pkg::VEC_W-1:0] last_vec;
    logic req;
    logic we;

    // -------------------------------------------------------------
    // wishbone decode
    // -------------------------------------------------------------
    wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // a write lands at the edge where the master samples ack, while its request still stands
    wire wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
    wire wr_cmd = wr & (wb_adr_i == cei_pkg::WB_CMD) & wb_sel_i[0];
    wire go_rd = wr_cmd & wb_dat_i[cei_pkg::CMD_RD_BIT];
    wire go_wr = wr_cmd & wb_dat_i[cei_pkg::CMD_WR_BIT];
    // commands while busy are dropped; write wins if both bits set
    wire start = (go_rd | go_wr) & (state == cei_pkg::HST_IDLE);
    wire [cei_pkg::NTHR-1:0] pend_clr = (wr & (wb_adr_i == cei_pkg::WB_PEND) & wb_sel_i[0])
                                        ? wb_dat_i[cei_pkg::NTHR-1:0] : 2'h0;
    wire [31:0] cmd_word = {16'h0, last_vec, 6'h0, done, busy};
    wire [31:0] rd_word = (wb_adr_i == cei_pkg::WB_ADDR) ? tgt_addr
                        : (wb_adr_i == cei_pkg::WB_WLO) ? wdata[31:0]
                        : (wb_adr_i == cei_pkg::WB_WHI) ? wdata[63:32]
                        : (wb_adr_i == cei_pkg::WB_CMD) ? cmd_word
                        : (wb_adr_i == cei_pkg::WB_RLO) ? rdata[31:0]
                        : (wb_adr_i == cei_pkg::WB_RHI) ? rdata[63:32]
                        : (wb_adr_i == cei_pkg::WB_PEND) ? 32'(pend)
                        : 32'h0;

    // -------------------------------------------------------------
    // wishbone slave: ack one cycle after the strobe, dropped the next
    // -------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            tgt_addr <= 32'h0;
            wdata <= 64'h0;
        end
        else
        begin
            wb_ack_o <= acc;
            wb_dat_o <= rd_word;
            if (wr & (wb_adr_i == cei_pkg::WB_ADDR))
                tgt_addr <= merge(tgt_addr, wb_dat_i, wb_sel_i) & 32'h0000_0fff;
            if (wr & (wb_adr_i == cei_pkg::WB_WLO))
                wdata[31:0] <= merge(wdata[31:0], wb_dat_i, wb_sel_i);
            if (wr & (wb_adr_i == cei_pkg::WB_WHI))
                wdata[63:32] <= merge(wdata[63:32], wb_dat_i, wb_sel_i);
        end
    end

    // -------------------------------------------------------------
    // link sequencer: one-cycle request, wait for the answer
    // -------------------------------------------------------------
    // software claims a bank by a write of the enable bit then a read-back; serialising threads is its job
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= cei_pkg::HST_IDLE;
            req <= 1'b0;
            we <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= 64'h0;
        end
        else
        begin
            req <= 1'b0;
            case (state)
                cei_pkg::HST_IDLE:
                begin
                    if (start)
                    begin
                        req <= 1'b1;
                        we <= go_wr;
                        busy <= 1'b1;
                        done <= 1'b0;
                        state <= cei_pkg::HST_WAIT;
                    end
                end
                cei_pkg::HST_WAIT:
                begin
                    if (link.ack)
                    begin
                        if (~we)
                            rdata <= link.rdata;
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= cei_pkg::HST_IDLE;
                    end
                end
                default:
                    state <= cei_pkg::HST_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------
    // interrupt capture: an arriving pulse wins over a clear
    // -------------------------------------------------------------
    // the handler reads pend and services only the banks its thread owns
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend <= 2'h0;
            last_vec <= 8'h0;
        end
        else
        begin
            pend <= (pend & ~pend_clr) | link.irq;
            if (|link.irq)
                last_vec <= link.vector;
        end
    end

    assign link.req = req;
    assign link.we = we;
    assign link.addr = tgt_addr[cei_pkg::ADDR_W-1:0];
    assign link.wdata = wdata;

endmodule

// file: cei_props.sv
// link checker for the corrected-error interrupt device and its host
`timescale 1ns/100ps
module cei_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req,
    input wire logic we,
    input wire logic [11:0] addr,
    input wire logic [63:0] wdata,
    input wire logic ack,
    input wire logic [63:0] rdata,
    input wire logic [1:0] irq,
    input wire logic [7:0] vector
);
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    wire rd = req && !we; // link read request
    logic en_seen; // some bank enable written since reset
    always_ff @(posedge clk_i)
    begin
        en_seen <= rst_i ? 1'b0 : en_seen | (req && we && addr[11:8] == 4'h1 && wdata[30]);
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // -------------------------------------------------------------
    // properties
    // -------------------------------------------------------------
    property p_ack; req |=> ack; endproperty
    a_ack: assert property (p_ack) else $error("link ack missing");
    property p_ack_cause; ack |-> $past(req); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("link ack without request");
    property p_ack_once; ack |=> !ack; endproperty
    a_ack_once: assert property (p_ack_once) else $error("link ack too long");
    property p_cap; rd && addr == 12'h000 |=> rdata[7:0] == 8'h04 && rdata[10] && rdata[24]; endproperty
    a_cap: assert property (p_cap) else $error("capability fields wrong");
    property p_nothr; rd && addr == 12'h103 |=> rdata[30] == 1'b0 && rdata[15:0] == 16'h0; endproperty
    a_nothr: assert property (p_nothr) else $error("bank without threshold reads nonzero");
    property p_max; rd && addr[11:8] == 4'h1 |=> rdata[14:0] <= 15'h0fff; endproperty
    a_max: assert property (p_max) else $error("threshold above maximum");
    property p_quiet; !en_seen |-> irq == 2'b00; endproperty
    a_quiet: assert property (p_quiet) else $error("interrupt before any enable");
    property p_vec; req && we && addr == 12'h2f0 |-> ##2 vector == $past(wdata[7:0], 2); endproperty
    a_vec: assert property (p_vec) else $error("vector entry not followed");
endmodule

// file: cei_test.sv
// self-checking bench: host controller and device joined over the link
`timescale 1ns/100ps
module cei_test;
    logic clk_i, rst_i, cyc, stb, wbwe, ack, err_v, mce;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [63:0] d;
    logic [1:0] err_b;
    cei_pkg::cei_kind_e err_k;
    cei_pkg::cei_scope_e err_s;
    int n_errors = 0, cmp_count = 0, cycles = 0, mce_n = 0, m0;
    logic [1:0] pexp [4] = '{2'b01, 2'b10, 2'b11, 2'b11}; // pend per scope
    cei_if link_if();
    cei_dev cei_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link_if.dev), .err_valid_i(err_v),
        .err_bank_i(err_b), .err_kind_i(err_k), .err_scope_i(err_s), .mce_o(mce));
    cei_host cei_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wbwe),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .link(link_if.host));
    cei_props cei_props_inst (.clk_i(clk_i), .rst_i(rst_i), .req(link_if.req), .we(link_if.we),
        .addr(link_if.addr), .wdata(link_if.wdata), .ack(link_if.ack), .rdata(link_if.rdata),
        .irq(link_if.irq), .vector(link_if.vector));
    // -------------------------------------------------------------
    // clock, watchdog and exception-path pulse counter
    // -------------------------------------------------------------
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        mce_n <= mce_n + (mce === 1'b1);
        if (cycles == 20000)
        begin
            n_errors++; // a hang counts as a mismatch
            test_done;
        end
    end
    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        cmp_count++;
        if (got !== exp)
            $display("CHECK FAILED %0t %s got %h", $time, m, got);
        if (got !== exp)
            n_errors++;
    endtask
    // -------------------------------------------------------------
    // classic wishbone cycle, then link accesses built on it
    // -------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv, output logic [31:0] r);
        cyc <= 1'b1;
        stb <= 1'b1;
        wbwe <= w;
        adr <= a;
        wdat <= dv;
        do @(posedge clk_i); while (ack !== 1'b1); // only the watchdog ends a wait
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i); // idle cycle between accesses
    endtask
    task automatic wait_idle; // poll busy until the link answer is in
        logic [31:0] r;
        do wb(1'b0, cei_pkg::WB_CMD, 32'h0, r); while (r[0] !== 1'b0);
    endtask
    task automatic lwr(input logic [11:0] a, input logic [63:0] dv);
        wb(1'b1, cei_pkg::WB_ADDR, {20'h0, a}, q);
        wb(1'b1, cei_pkg::WB_WLO, dv[31:0], q);
        wb(1'b1, cei_pkg::WB_WHI, dv[63:32], q);
        wb(1'b1, cei_pkg::WB_CMD, 32'h2, q);
        wait_idle;
    endtask
    task automatic lrd(input logic [11:0] a, output logic [63:0] dv);
        wb(1'b1, cei_pkg::WB_ADDR, {20'h0, a}, q);
        wb(1'b1, cei_pkg::WB_CMD, 32'h1, q);
        wait_idle;
        wb(1'b0, cei_pkg::WB_RLO, 32'h0, dv[31:0]);
        wb(1'b0, cei_pkg::WB_RHI, 32'h0, dv[63:32]);
    endtask
    task automatic ev(input int b, input int k, input int s, input logic [1:0] pe);
        err_v <= 1'b1;
        err_b <= 2'(b);
        err_k <= cei_pkg::cei_kind_e'(k);
        err_s <= cei_pkg::cei_scope_e'(s);
        @(posedge clk_i);
        err_v <= 1'b0;
        repeat (3) @(posedge clk_i);
        wb(1'b0, cei_pkg::WB_PEND, 32'h0, q);
        chk(q[1:0], pe, "pending threads");
        wb(1'b1, cei_pkg::WB_PEND, 32'h3, q); // clear pending
    endtask
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {cyc, stb, wbwe, err_v, adr, wdat, err_b} = '0;
        err_k = cei_pkg::KIND_CORR;
        err_s = cei_pkg::SCOPE_T0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        lrd(12'h000, d);
        chk({d[24], d[10], d[7:0]}, {cei_pkg::SER_SUPPORT, 1'b1, 8'h04}, "capability");
        lrd(12'h100, d);
        chk(d, 64'h0, "control after reset");
        lrd(12'h2f0, d);
        chk(d[31:0], cei_pkg::VEC_RESET, "vector entry reset");
        ev(0, 0, 2, 2'b00);
        for (int i = 0; i < 4; i++)
        begin
            lwr(12'h100 + 12'(i), 64'h4000_7fff);
            lrd(12'h100 + 12'(i), d);
            chk(d, {33'h0, cei_pkg::BANK_HAS_CEI[i], 15'h0, cei_pkg::BANK_HAS_THR[i] ? cei_pkg::THR_MAX : 15'h0},
                "probe");
        end
        ev(3, 0, 3, 2'b00);
        lrd(12'h203, d);
        chk(d, 64'h0, "bank without signalling counts");
        lwr(12'h101, 64'h4000_8123);
        lrd(12'h101, d);
        chk(d, 64'h4000_8123, "threshold readback");
        lwr(12'h2f0, 64'h42);
        lwr(12'h100, 64'h4000_0001);
        for (int s = 0; s < 4; s++)
        begin
            lwr(12'h200, 64'h0);
            ev(0, 0, s, pexp[s]);
        end
        ev(0, 0, 2, 2'b00);
        wb(1'b0, cei_pkg::WB_CMD, 32'h0, q);
        chk(q[15:8], 8'h42, "delivered vector");
        lwr(12'h101, 64'h4000_0001);
        for (int k = 1; k < 5; k++)
        begin
            lwr(12'h201, 64'h0);
            m0 = mce_n;
            ev(1, k, 2, k < 3 ? 2'b11 : 2'b00);
            chk(mce_n - m0, (k == 3), "exception path");
        end
        lwr(12'h102, 64'h4000_0002);
        ev(2, 0, 0, 2'b00);
        ev(2, 0, 0, 2'b01);
        lrd(12'h202, d);
        chk({d[63], d[52:38]}, {1'b1, 15'h2}, "status count");
        test_done;
    end
endmodule
